// file: ftd_consts.svh
// Purpose: Constants for the fourteen-bit instruction decoder
// Assumes: Included by the package and the design modules
// Notes:   Field positions, opcode codes, timing counts
`ifndef FTD_CONSTS_SVH
`define FTD_CONSTS_SVH

// Instruction word and group field
`define FTD_IW           14
`define FTD_GRP_BYTE     2'h0
`define FTD_GRP_BIT      2'h1
`define FTD_GRP_BRANCH   2'h2
`define FTD_GRP_LIT      2'h3

// Byte-oriented operation field
`define FTD_B_MISC       4'h0
`define FTD_B_CLR        4'h1
`define FTD_B_SUB        4'h2
`define FTD_B_DEC        4'h3
`define FTD_B_IOR        4'h4
`define FTD_B_AND        4'h5
`define FTD_B_XOR        4'h6
`define FTD_B_ADD        4'h7
`define FTD_B_MOV        4'h8
`define FTD_B_COM        4'h9
`define FTD_B_INC        4'hA
`define FTD_B_DECSZ      4'hB
`define FTD_B_RRC        4'hC
`define FTD_B_RLC        4'hD
`define FTD_B_SWAP       4'hE
`define FTD_B_INCSZ      4'hF

// Fixed control words (low byte, operation field 0000, dest 0)
`define FTD_W_RETURN     8'h08
`define FTD_W_RETINT     8'h09
`define FTD_W_SLEEP      8'h63
`define FTD_W_WDT        8'h64

// Literal field (bits 11:8)
`define FTD_L_IOR        4'h8
`define FTD_L_AND        4'h9
`define FTD_L_XOR        4'hA

// Special file addresses and status bit positions
`define FTD_ADDR_TIMER   7'h01
`define FTD_ADDR_PORT    7'h05
`define FTD_ST_C         0
`define FTD_ST_DC        1
`define FTD_ST_Z         2
`define FTD_ST_PWRDN     3
`define FTD_ST_TO        4
// Status after reset: expiry and powerdown flags set
`define FTD_ST_RST       5'h18

// Timing: instruction cycle in oscillator periods
`define FTD_OSC_PER_CYC  4
`define FTD_STACK_DEPTH  8

`endif

// file: ftd_pkg.sv
// Purpose: Types for the fourteen-bit instruction decoder
// Assumes: ftd_consts.svh supplies numeric constants
// Notes:   Types only
package ftd_pkg;
  `include "ftd_consts.svh"
  typedef enum logic [1:0] {FTD_FETCH, FTD_EXEC, FTD_FLUSH, FTD_HALT} ftd_state_t;
endpackage

// file: ftd_alu.sv
// Purpose: Arithmetic and logic unit for the instruction decoder
// Assumes: Operands and carry in are stable during the execute phase
// Notes:   Purely combinational; carry is computed only for add, subtract and rotates, half carry only for add and subtract
`timescale 1ns/1ps
`include "ftd_consts.svh"
module ftd_alu
  import ftd_pkg::*;
(
  // Operation select
  input  wire logic [3:0] op_i,
  input  wire logic       lit_i,
  // Operands
  input  wire logic [7:0] acc_i,
  input  wire logic [7:0] opnd_i,
  input  wire logic       carry_i,
  // Results
  output logic [7:0]      res_o,
  output logic            c_o,
  output logic            dc_o
);
  logic [8:0] sum;
  logic [4:0] hsum;
  logic [8:0] dif;
  logic [4:0] hdif;

  // Sums and differences; carry means no borrow on subtract
  always_comb begin
    sum  = {1'b0, opnd_i} + {1'b0, acc_i};
    hsum = {1'b0, opnd_i[3:0]} + {1'b0, acc_i[3:0]};
    dif  = {1'b0, opnd_i} + {1'b0, ~acc_i} + 9'h001;
    hdif = {1'b0, opnd_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
    res_o = opnd_i;
    c_o   = carry_i;
    dc_o  = 1'b0;
    if (lit_i) begin
      case (op_i)
        `FTD_L_IOR: res_o = opnd_i | acc_i;
        `FTD_L_AND: res_o = opnd_i & acc_i;
        `FTD_L_XOR: res_o = opnd_i ^ acc_i;
        4'hC, 4'hD: begin
          res_o = dif[7:0];
          c_o   = dif[8];
          dc_o  = hdif[4];
        end
        4'hE, 4'hF: begin
          res_o = sum[7:0];
          c_o   = sum[8];
          dc_o  = hsum[4];
        end
        default: res_o = opnd_i;
      endcase
    end else begin
      case (op_i)
        `FTD_B_MISC:  res_o = acc_i;
        `FTD_B_CLR:   res_o = 8'h00;
        `FTD_B_SUB: begin
          res_o = dif[7:0];
          c_o   = dif[8];
          dc_o  = hdif[4];
        end
        `FTD_B_DEC, `FTD_B_DECSZ: res_o = opnd_i - 8'h01;
        `FTD_B_IOR:   res_o = acc_i | opnd_i;
        `FTD_B_AND:   res_o = acc_i & opnd_i;
        `FTD_B_XOR:   res_o = acc_i ^ opnd_i;
        `FTD_B_ADD: begin
          res_o = sum[7:0];
          c_o   = sum[8];
          dc_o  = hsum[4];
        end
        `FTD_B_MOV:   res_o = opnd_i;
        `FTD_B_COM:   res_o = ~opnd_i;
        `FTD_B_INC, `FTD_B_INCSZ: res_o = opnd_i + 8'h01;
        `FTD_B_RRC: begin
          res_o = {carry_i, opnd_i[7:1]};
          c_o   = opnd_i[0];
        end
        `FTD_B_RLC: begin
          res_o = {opnd_i[6:0], carry_i};
          c_o   = opnd_i[7];
        end
        `FTD_B_SWAP:  res_o = {opnd_i[3:0], opnd_i[7:4]};
        default:      res_o = opnd_i;
      endcase
    end
  end
endmodule

// file: ftd_core.sv
// Purpose: Decode and execute fourteen-bit instruction words
// Assumes: Program memory answers a fetch address within the same quarter
// Notes:   Four clock phases form one instruction cycle
//
// Notes on behaviour
// RULE1 - Byte format 00/op/d/f; xor of accumulator with register sets zero flag.
// RULE2 - Byte or (0100) and and (0101) set only zero flag, one cycle.
// RULE3 - 1011 decrements and skips on zero, no flags; 0011 decrements, sets zero.
// RULE4 - 1111 increments and skips on zero, no flags; 1010 increments, sets zero.
// RULE5 - 1101 rotates left through carry, only carry changes.
// RULE6 - 1100 rotates right through carry; 1110 swaps nibbles, no flags.
// RULE7 - Bit format 01/op/b/f; op 10 skips when selected bit clear.
// RULE8 - Op 11 skips when bit set; 00 clears, 01 sets; no flags.
// RULE9 - Literal format 11 with 8-bit literal; 1000 ors literal, sets zero.
// RULE10 - Literal 1010 xors, 1001 ands into accumulator; zero flag only.
// RULE11 - 110x literal minus accumulator, 111x adds; set carry, half carry, zero.
// RULE12 - 01xx loads literal and returns in two cycles; 00xx loads, no flags.
// RULE13 - Standby word enters standby and updates expiry and powerdown flags.
// RULE14 - Program counter change or true test costs a second no-operation cycle.
// RULE15 - Port read-modify-write uses pin levels, not output latch.
// RULE16 - Writing timer zero count clears the prescaler when assigned to it.
// RULE17 - One instruction cycle lasts four oscillator periods.
// RULE18 - Destination zero writes accumulator, one writes the file register.
// RULE19 - File register instructions read the register first, then store.
// RULE20 - Top bits 10 branch in two cycles; bit 11 clear calls, set jumps.
// RULE21 - Fixed words: 08 return, 09 interrupt return, 64 watchdog kick, nop.
`timescale 1ns/1ps
`include "ftd_consts.svh"
module ftd_core
  import ftd_pkg::*;
#(
  parameter int PC_W = 13
)(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Program memory
  input  wire logic [13:0]      insn_i,
  output logic      [PC_W-1:0]  program_counter_o,
  // File register read and write
  output logic      [6:0]       file_addr_o,
  input  wire logic [7:0]       file_rdata_i,
  output logic                  file_rd_o,
  output logic                  file_we_o,
  output logic      [7:0]       file_wdata_o,
  // Port pins and timer zero
  input  wire logic [7:0]       port_pins_i,
  input  wire logic             prescaler_to_timer_i,
  output logic                  prescaler_clr_o,
  // Core state
  input  wire logic             wake_i,
  output logic      [7:0]       acc_o,
  output logic      [4:0]       status_o,
  output logic                  standby_o,
  output logic                  watchdog_kick_o,
  output logic                  int_enable_o
);
  ftd_state_t state;
  logic [1:0]      phase;
  logic [13:0]     ir;
  logic [7:0]      acc;
  logic [4:0]      st;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] stack [`FTD_STACK_DEPTH];
  logic [2:0]      sp;
  logic [7:0]      pin_m;
  logic [7:0]      pin_s;
  logic            wake_m;
  logic            wake_s;

  // Decoded fields
  wire [1:0] grp     = ir[13:12];
  wire [3:0] bop     = ir[11:8];
  wire       dest    = ir[7];
  wire [6:0] faddr   = ir[6:0];
  wire [2:0] bsel    = ir[9:7];
  wire [7:0] lit     = ir[7:0];
  wire       is_byte = (grp == `FTD_GRP_BYTE);
  wire       is_bit  = (grp == `FTD_GRP_BIT);
  wire       is_br   = (grp == `FTD_GRP_BRANCH);
  wire       is_lit  = (grp == `FTD_GRP_LIT);
  wire       is_misc = is_byte && bop == `FTD_B_MISC && !dest;
  wire       w_ret   = is_misc && lit == `FTD_W_RETURN;    // [RULE21]
  wire       w_reti  = is_misc && lit == `FTD_W_RETINT;    // [RULE21]
  wire       w_wdt   = is_misc && lit == `FTD_W_WDT;       // [RULE21]
  wire       w_sleep = is_misc && lit == `FTD_W_SLEEP;     // [RULE13]
  wire       l_return_with_literal = is_lit && bop[3:2] == 2'h1;         // [RULE12]
  wire       l_load_literal_acc = is_lit && bop[3:2] == 2'h0;         // [RULE12]
  // Clear-to-accumulator and no-operation words carry no file operand
  wire       uses_f  = (is_byte && !(bop == `FTD_B_MISC && !dest)
                        && !(bop == `FTD_B_CLR && !dest)) || is_bit;

  // Pin levels replace the latch when the port is read [RULE15]
  wire [7:0] opnd_f  = (faddr == `FTD_ADDR_PORT) ? pin_s : file_rdata_i;
  wire [7:0] opnd    = is_lit ? lit : opnd_f;

  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_dc;
  ftd_alu u_alu (
    .op_i    (bop),
    .lit_i   (is_lit),
    .acc_i   (acc),
    .opnd_i  (opnd),
    .carry_i (st[`FTD_ST_C]),
    .res_o   (alu_res),
    .c_o     (alu_c),
    .dc_o    (alu_dc)
  );

  // Bit-group result and test [RULE7] [RULE8]
  wire [7:0] bmask   = 8'h01 << bsel;
  wire       bval    = |(opnd_f & bmask);
  wire [7:0] bit_res = bop[2] ? (opnd_f | bmask) : (opnd_f & ~bmask);
  wire       bit_tst = is_bit && bop[3];
  wire       bit_skp = bit_tst && (bop[2] ? bval : !bval);   // [RULE7] [RULE8]
  wire       sz_op   = is_byte && (bop == `FTD_B_DECSZ || bop == `FTD_B_INCSZ);
  wire       sz_skp  = sz_op && alu_res == 8'h00;            // [RULE3] [RULE4]
  wire       pc_chg  = is_br || w_ret || w_reti || l_return_with_literal;  // [RULE20]
  wire       two_cyc = pc_chg || bit_skp || sz_skp;          // [RULE14]

  // Result destination [RULE18]
  wire [7:0] result  = is_bit ? bit_res : alu_res;
  wire       to_file = (is_byte && dest && !is_misc) || (is_bit && !bit_tst);
  wire       to_acc  = (is_byte && !dest && !is_misc) || (is_lit && bop != 4'hB);

  // Flag classes: zero only, full arithmetic, carry only
  wire z_only = (is_byte && (bop == `FTD_B_IOR || bop == `FTD_B_AND   // [RULE2]
                || bop == `FTD_B_XOR || bop == `FTD_B_DEC              // [RULE1] [RULE3]
                || bop == `FTD_B_INC || bop == `FTD_B_CLR              // [RULE4]
                || bop == `FTD_B_MOV || bop == `FTD_B_COM) && !is_misc)
                || (is_lit && (bop == `FTD_L_IOR || bop == `FTD_L_AND  // [RULE9]
                || bop == `FTD_L_XOR));                                // [RULE10]
  wire arith  = (is_byte && (bop == `FTD_B_ADD || bop == `FTD_B_SUB))
                || (is_lit && bop[3:2] == 2'h3);                       // [RULE11]
  wire c_only = is_byte && (bop == `FTD_B_RLC || bop == `FTD_B_RRC);   // [RULE5] [RULE6]

  logic [4:0] next_st;
  always_comb begin
    next_st = st;
    if (z_only || arith) begin
      next_st[`FTD_ST_Z] = (result == 8'h00);
    end
    if (arith || c_only) begin
      next_st[`FTD_ST_C] = alu_c;
    end
    if (arith) begin
      next_st[`FTD_ST_DC] = alu_dc;
    end
    if (w_sleep) begin                                                 // [RULE13]
      next_st[`FTD_ST_TO] = 1'b1;
      next_st[`FTD_ST_PWRDN] = 1'b0;
    end else if (w_wdt) begin
      next_st[`FTD_ST_TO] = 1'b1;
      next_st[`FTD_ST_PWRDN] = 1'b1;
    end
  end

  // Program counter target
  wire [PC_W-1:0] pc_inc = pc + {{(PC_W-1){1'b0}}, 1'b1};
  wire [2:0]      sp_top = sp - 3'h1;
  wire [PC_W-1:0] pc_tgt = is_br ? {pc[PC_W-1:11], ir[10:0]} : stack[sp_top];
  wire            exec_q = state == FTD_EXEC && phase == 2'h3;
  wire            tmr_wr = exec_q && to_file && faddr == `FTD_ADDR_TIMER;
  // A taken skip steps over the word behind it; the flush cycle only idles
  wire [PC_W-1:0] pc_two  = pc + {{(PC_W-2){1'b0}}, 2'h2};
  wire            skip    = bit_skp || sz_skp;                     // [RULE3] [RULE7]
  wire [PC_W-1:0] next_pc = !exec_q ? pc : (pc_chg ? pc_tgt : (skip ? pc_two : pc_inc));

  // Pin and wake synchronisers; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    pin_m  <= port_pins_i;
    pin_s  <= pin_m;
    wake_m <= wake_i;
    wake_s <= wake_m;
  end

  // Four-phase instruction cycle counter [RULE17]
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Sequencer: fetch in phase 0, read in 1, modify-write in 3 [RULE19]
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= FTD_FETCH;
      ir    <= 14'h0000;
      pc    <= '0;
      sp    <= 3'h0;
    end else if (phase == 2'h3) begin
      case (state)
        FTD_FETCH: begin
          state <= FTD_EXEC;
        end
        FTD_EXEC: begin
          pc    <= next_pc;                                  // [RULE14]
          state <= w_sleep ? FTD_HALT : (two_cyc ? FTD_FLUSH : FTD_EXEC);
          if (is_br && !ir[11]) begin                        // [RULE20]
            stack[sp] <= pc_inc;
            sp        <= sp + 3'h1;
          end else if (w_ret || w_reti || l_return_with_literal) begin     // [RULE12] [RULE21]
            sp <= sp_top;
          end
        end
        FTD_FLUSH: begin                                     // [RULE14]
          state <= FTD_EXEC;
        end
        default: begin
          state <= wake_s ? FTD_FETCH : FTD_HALT;
        end
      endcase
    end
    if (phase == 2'h0 && state != FTD_HALT) begin
      ir <= insn_i;
    end
  end

  // Execute-phase register updates
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc             <= 8'h00;
      st              <= `FTD_ST_RST;
      file_addr_o     <= 7'h00;
      file_rd_o       <= 1'b0;
      file_we_o       <= 1'b0;
      file_wdata_o    <= 8'h00;
      prescaler_clr_o <= 1'b0;
      watchdog_kick_o <= 1'b0;
      int_enable_o    <= 1'b0;
    end else begin
      file_addr_o     <= faddr;
      // Strobe once the new word sits in ir, so strobe and address agree
      file_rd_o       <= state == FTD_EXEC && phase == 2'h1 && uses_f; // [RULE19]
      file_we_o       <= exec_q && to_file;                            // [RULE18]
      file_wdata_o    <= result;
      prescaler_clr_o <= tmr_wr && prescaler_to_timer_i;               // [RULE16]
      watchdog_kick_o <= exec_q && w_wdt;
      if (exec_q) begin
        st <= next_st;
        if (to_acc) begin
          acc <= l_load_literal_acc || l_return_with_literal ? lit : result;                   // [RULE12]
        end
        if (w_reti) begin
          int_enable_o <= 1'b1;
        end
      end
    end
  end

  // Outputs from flip-flops
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      program_counter_o <= '0;
      acc_o             <= 8'h00;
      status_o          <= `FTD_ST_RST;
      standby_o         <= 1'b0;
    end else begin
      program_counter_o <= next_pc;  // Loaded from next_pc on the same edge as pc, so the phase-0 fetch sees the new address
      acc_o             <= acc;
      status_o          <= st;
      standby_o         <= state == FTD_HALT;
    end
  end

  // Checks
  a_rot_carry_only: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE5]
    exec_q && c_only |=> st[`FTD_ST_Z] == $past(st[`FTD_ST_Z]))
    else $error("rotate changed zero flag");
  a_skip_flush: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE14]
    exec_q && two_cyc && !w_sleep |=> state == FTD_FLUSH)
    else $error("two-cycle op did not flush");
  a_bit_no_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE8]
    exec_q && is_bit |=> st == $past(st))
    else $error("bit op changed flags");
  a_tmr_presc: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE16]
    tmr_wr && prescaler_to_timer_i |=> prescaler_clr_o)
    else $error("prescaler not cleared");
  a_sleep_halt: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE13]
    exec_q && w_sleep |=> state == FTD_HALT ##1 standby_o)
    else $error("standby not entered");
  a_load_literal_acc_load: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE12]
    exec_q && l_load_literal_acc |=> acc == $past(lit) && st == $past(st))
    else $error("literal load wrong");
  a_read_first: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE19]
    exec_q && to_file |-> $past(file_rd_o))
    else $error("write without prior read");
  a_dest_acc: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE18]
    exec_q && is_byte && !dest && !is_misc |=> !file_we_o)
    else $error("accumulator result written to file");
  a_phase_wrap: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE17]
    phase == 2'h3 |=> phase == 2'h0)
    else $error("cycle not four phases");
  a_fetch_addr: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE14]
    phase == 2'h0 |-> program_counter_o == pc)
    else $error("fetch address behind program counter");
  c_sleep: cover property (@(posedge clk_i) exec_q && w_sleep);
  c_skip: cover property (@(posedge clk_i) exec_q && sz_skp);
  c_call: cover property (@(posedge clk_i) exec_q && is_br && !ir[11]);
  c_return_with_literal: cover property (@(posedge clk_i) exec_q && l_return_with_literal);
endmodule

// file: ftd_prog_mem.sv
// Purpose: Program memory and file register model facing the decoder
// Assumes: The bench loads rom and regs while reset is held
// Notes:   Read data is valid in the read strobe cycle and the two cycles after it only
`timescale 1ns/1ps
module ftd_prog_mem (
  // Clock
  input  wire logic        clk_i,
  // Fetch side
  input  wire logic [12:0] pc_i,
  output logic      [13:0] insn_o,
  // File register side
  input  wire logic [6:0]  addr_i,
  input  wire logic        rd_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  logic [13:0] rom [0:31];
  logic [7:0]  regs [0:127];
  logic [1:0]  hold = 2'h0;
  logic [7:0]  last = 8'h00;
  wire         valid = rd_i || (hold != 2'h0);

  // Fetch answers within the same cycle
  assign insn_o  = rom[pc_i[4:0]];
  // Outside the window show the inverse, so stale data never looks good
  assign rdata_o = valid ? regs[addr_i] : ~last;

  // Read window, last value seen and register writes
  always @(posedge clk_i) begin
    hold <= rd_i ? 2'h2 : (valid ? hold - 2'h1 : 2'h0);
    if (valid) last <= regs[addr_i];
    if (we_i) regs[addr_i] <= wdata_i;
  end
endmodule

// file: fourteen_bit_insn_decoder_bench.sv
// Purpose: Self-checking bench for the fourteen-bit instruction decoder
// Assumes: Each program ends in a jump to itself and settles in 120 clocks
// Notes:   Results are read from the file register model and core outputs
`timescale 1ns/1ps
`include "ftd_consts.svh"
module fourteen_bit_insn_decoder_bench;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  pins = 8'h00;
  logic        tmr_asg = 1'b0;
  logic        wake = 1'b0;
  logic [13:0] insn;
  logic [12:0] pc;
  logic [6:0]  faddr;
  logic [7:0]  frdata, fwdata, acc;
  logic [4:0]  status;
  logic        frd, fwe, pclr, standby, kick, int_en;
  int          miscompares = 0, comparisons = 0, cyc = 0, rd_n = 0, clr_n = 0, kick_n = 0;
  int          we_t[$];
  logic [13:0] prog[$];

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  ftd_core #(.PC_W(13)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .insn_i(insn), .program_counter_o(pc),
    .file_addr_o(faddr), .file_rdata_i(frdata), .file_rd_o(frd), .file_we_o(fwe),
    .file_wdata_o(fwdata), .port_pins_i(pins), .prescaler_to_timer_i(tmr_asg),
    .prescaler_clr_o(pclr), .wake_i(wake), .acc_o(acc), .status_o(status),
    .standby_o(standby), .watchdog_kick_o(kick), .int_enable_o(int_en)
  );

  ftd_prog_mem pm (
    .clk_i(clk_i), .pc_i(pc), .insn_o(insn), .addr_i(faddr), .rd_i(frd),
    .we_i(fwe), .wdata_i(fwdata), .rdata_o(frdata)
  );

  // Cycle count, pulse counts, write times and the hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (frd === 1'b1) rd_n <= rd_n + 1;
    if (pclr === 1'b1) clr_n <= clr_n + 1;
    if (kick === 1'b1) kick_n <= kick_n + 1;
    if (fwe === 1'b1) we_t.push_back(cyc);
    if (cyc == 3000) begin
      miscompares++;
      end_sim();
    end
  end

  // Instruction word builders
  function automatic logic [13:0] bw(input logic [3:0] op, input logic d, input logic [6:0] f);
    return {2'b00, op, d, f};
  endfunction
  function automatic logic [13:0] bt(input logic [1:0] op, input logic [2:0] b, input logic [6:0] f);
    return {2'b01, op, b, f};
  endfunction
  function automatic logic [13:0] lt(input logic [3:0] op, input logic [7:0] k);
    return {2'b11, op, k};
  endfunction
  function automatic logic [13:0] br(input logic j, input logic [10:0] k);
    return {2'b10, j, k};
  endfunction

  // Comparisons, one per kind of result
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp5(input logic [4:0] got, input logic [4:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpn(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Hold reset 12 cycles, load the program, clear the file registers
  task automatic boot(input logic asg);
    sys_rst_i <= 1'b1;
    tmr_asg   <= asg;
    repeat (12) @(posedge clk_i);
    foreach (pm.rom[i]) pm.rom[i] = (i < prog.size()) ? prog[i] : 14'h0000;
    foreach (pm.regs[i]) pm.regs[i] = 8'h00;
    we_t.delete();
    rd_n   <= 0;
    clr_n  <= 0;
    kick_n <= 0;
  endtask
  task automatic go();
    sys_rst_i <= 1'b0;
    repeat (120) @(posedge clk_i);
  endtask

  task automatic end_sim();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    pins <= 8'hA5;
    // Literal load, or, and, xor
    prog = {lt(4'h0, 8'hF0), lt(`FTD_L_IOR, 8'h0F), lt(`FTD_L_AND, 8'h3C),
            lt(`FTD_L_XOR, 8'h3C), br(1'b1, 11'h004)};
    boot(1'b0);
    go();
    cmp8(acc, 8'h00);
    cmp5(status, 5'h1C);
    // Add with carry out of both nibbles
    prog = {lt(4'h0, 8'h8F), lt(4'hE, 8'h71), br(1'b1, 11'h002)};
    boot(1'b0);
    go();
    cmp8(acc, 8'h00);
    cmp5(status, 5'h1F);
    // Literal minus accumulator, borrow from the low nibble
    prog = {lt(4'h0, 8'h01), lt(4'hC, 8'h10), br(1'b1, 11'h002)};
    boot(1'b0);
    go();
    cmp8(acc, 8'h0F);
    cmp5(status, 5'h19);
    // Byte logic ops with both destinations
    prog = {lt(4'h0, 8'hF0), bw(`FTD_B_IOR, 1'b1, 7'h20), bw(`FTD_B_AND, 1'b0, 7'h20),
            bw(`FTD_B_XOR, 1'b1, 7'h20), br(1'b1, 11'h004)};
    boot(1'b0);
    pm.regs[7'h20] = 8'h0F;
    go();
    cmp8(pm.regs[7'h20], 8'h0F);
    cmp8(acc, 8'hF0);
    cmp5(status, 5'h18);
    // Decrement and increment, with and without skip; write spacing
    prog = {bw(`FTD_B_DECSZ, 1'b1, 7'h26), bw(`FTD_B_INC, 1'b1, 7'h27),
            bw(`FTD_B_DECSZ, 1'b1, 7'h21), bw(`FTD_B_INC, 1'b1, 7'h25),
            bw(`FTD_B_INCSZ, 1'b1, 7'h22), bw(`FTD_B_INC, 1'b1, 7'h25),
            bw(`FTD_B_DEC, 1'b0, 7'h23), br(1'b1, 11'h007)};
    boot(1'b0);
    pm.regs[7'h26] = 8'h03;
    pm.regs[7'h21] = 8'h01;
    pm.regs[7'h22] = 8'hFF;
    pm.regs[7'h23] = 8'h01;
    go();
    cmp8(pm.regs[7'h26], 8'h02);
    cmp8(pm.regs[7'h27], 8'h01);
    cmp8(pm.regs[7'h21], 8'h00);
    cmp8(pm.regs[7'h22], 8'h00);
    cmp8(pm.regs[7'h25], 8'h00);
    cmp8(pm.regs[7'h23], 8'h01);
    cmp8(acc, 8'h00);
    cmp5(status, 5'h1C);
    cmpn(we_t.size(), 4);
    if (we_t.size() == 4) begin
      cmpn(we_t[1] - we_t[0], `FTD_OSC_PER_CYC);
      cmpn(we_t[2] - we_t[1], `FTD_OSC_PER_CYC);
      cmpn(we_t[3] - we_t[2], 2 * `FTD_OSC_PER_CYC);
    end
    // Rotates through carry and nibble exchange
    prog = {bw(`FTD_B_RLC, 1'b1, 7'h30), bw(`FTD_B_RRC, 1'b1, 7'h31),
            bw(`FTD_B_SWAP, 1'b1, 7'h32), br(1'b1, 11'h003)};
    boot(1'b0);
    pm.regs[7'h30] = 8'h81;
    pm.regs[7'h31] = 8'h81;
    pm.regs[7'h32] = 8'hA5;
    go();
    cmp8(pm.regs[7'h30], 8'h02);
    cmp8(pm.regs[7'h31], 8'hC0);
    cmp8(pm.regs[7'h32], 8'h5A);
    cmp5(status, 5'h19);
    // Byte add, subtract, complement and clear written back
    prog = {lt(4'h0, 8'h01), bw(`FTD_B_ADD, 1'b1, 7'h50), bw(`FTD_B_SUB, 1'b1, 7'h51),
            bw(`FTD_B_COM, 1'b1, 7'h52), bw(`FTD_B_CLR, 1'b1, 7'h53), br(1'b1, 11'h005)};
    boot(1'b0);
    pm.regs[7'h50] = 8'h0F;
    pm.regs[7'h51] = 8'h05;
    pm.regs[7'h53] = 8'h77;
    go();
    cmp8(pm.regs[7'h50], 8'h10);
    cmp8(pm.regs[7'h51], 8'h04);
    cmp8(pm.regs[7'h52], 8'hFF);
    cmp8(pm.regs[7'h53], 8'h00);
    cmp5(status, 5'h1F);
    // Bit set, clear, both tests taken, and the bit-clear test not taken
    prog = {bt(2'h1, 3'h7, 7'h40), bt(2'h0, 3'h0, 7'h41), bt(2'h2, 3'h0, 7'h41),
            bw(`FTD_B_INC, 1'b1, 7'h25), bt(2'h3, 3'h7, 7'h40), bw(`FTD_B_INC, 1'b1, 7'h25),
            bt(2'h2, 3'h7, 7'h40), bw(`FTD_B_INC, 1'b1, 7'h42), br(1'b1, 11'h008)};
    boot(1'b0);
    pm.regs[7'h41] = 8'hFF;
    go();
    cmp8(pm.regs[7'h40], 8'h80);
    cmp8(pm.regs[7'h41], 8'hFE);
    cmp8(pm.regs[7'h25], 8'h00);
    cmp8(pm.regs[7'h42], 8'h01);
    // Calls, return, interrupt exit and return with literal
    prog = {br(1'b0, 11'h005), br(1'b0, 11'h007), br(1'b0, 11'h008), lt(`FTD_L_XOR, 8'h0F),
            br(1'b1, 11'h004), lt(4'h0, 8'h11), 14'h0008, 14'h0009, lt(4'h4, 8'h3C)};
    boot(1'b0);
    go();
    cmp8(acc, 8'h33);
    cmp8({7'h00, int_en}, 8'h01);
    // Port read-modify-write, timer write with prescaler assigned, watchdog kick
    prog = {bw(`FTD_B_MOV, 1'b1, 7'h05), bw(`FTD_B_MISC, 1'b1, 7'h01), 14'h0064,
            br(1'b1, 11'h003)};
    boot(1'b1);
    go();
    cmp8(pm.regs[7'h05], 8'hA5);
    cmpn(clr_n, 1);
    cmpn(rd_n, 2);
    cmpn(kick_n, 1);
    cmp5(status, 5'h18);
    // Timer write unassigned, then standby and wake
    prog = {bw(`FTD_B_MISC, 1'b1, 7'h01), 14'h0063, bw(`FTD_B_INC, 1'b1, 7'h25),
            br(1'b1, 11'h003)};
    boot(1'b0);
    go();
    cmpn(clr_n, 0);
    cmp8({7'h00, standby}, 8'h01);
    cmp5(status, 5'h10);
    cmp8(pm.regs[7'h25], 8'h00);
    wake <= 1'b1;
    repeat (20) @(posedge clk_i);
    cmp8({7'h00, standby}, 8'h00);
    wake <= 1'b0;
    end_sim();
  end
endmodule
